// *** hw/tlip_top.sv ***
// Local design decision: register access over APB.
`timescale 1ns/10ps

// Summary of operation
// - Writing one to pending-set marks source pending
// - Writing one to pending-clear removes pending state, unless a source event arrives in the same cycle
// - Active register is read-only, shows serviced sources
// - Missed flags at bits 15..2; 1..0 zero
// - Same bit position per source in every register

module tlip_top
  import tlip_pkg::*;
#(
  parameter int SRC_W = TLIP_NUM_SRC
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [31:0]            paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [SRC_W-1:0]       src_event,
  input  wire logic                   ack_valid,
  input  wire logic [TLIP_IDX_W-1:0]  ack_index,
  input  wire logic                   done_valid,
  input  wire logic [TLIP_IDX_W-1:0]  done_index,
  output logic      [SRC_W-1:0]       pending_out,
  output logic      [SRC_W-1:0]       active_out,
  output logic                        irq
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (SRC_W < TLIP_NUM_SRC || SRC_W >= TLIP_DATA_W) begin : g_bad_width
    $error("tlip_top: SRC_W must cover all sources and stay below 32");
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // One-hot vector from a source index; out-of-range gives zero
  function automatic logic [SRC_W-1:0] tlip_onehot(input logic [TLIP_IDX_W-1:0] idx);
    logic [SRC_W-1:0] r;
    r = '0;
    if (int'(idx) < SRC_W) begin
      r[idx] = 1'b1;
    end
    return r;
  endfunction : tlip_onehot

  // Zero-extend a source vector to the bus width
  function automatic logic [31:0] tlip_widen(input logic [SRC_W-1:0] v);
    return {{(TLIP_DATA_W - SRC_W){1'b0}}, v};
  endfunction : tlip_widen

  // ****************************************************************
  // State
  // ****************************************************************
  logic [SRC_W-1:0] pending_q;
  logic [SRC_W-1:0] missed_q;
  logic [SRC_W-1:0] status_q;
  logic [SRC_W-1:0] active_q;
  logic [SRC_W-1:0] active_d;
  logic [SRC_W-1:0] irq_en_q;
  logic [SRC_W-1:0] irq_en_d;
  logic [31:0]      prdata_q;
  logic [31:0]      prdata_d;
  logic             pready_q;
  logic             pslverr_q;
  logic             pslverr_d;
  logic             irq_q;
  logic [SRC_W-1:0] pending_o_q;
  logic [SRC_W-1:0] active_o_q;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic             setup_phase;
  logic             access_done;
  logic             wr_done;
  logic             hit_pset;
  logic             hit_pclr;
  logic             hit_active;
  logic             hit_missed;
  logic             hit_status;
  logic             hit_clear;
  logic             hit_enable;
  logic             hit_any;
  logic             wr_pset;
  logic             wr_pclr;
  logic             wr_missed;
  logic             wr_clear;
  logic             wr_enable;
  logic [SRC_W-1:0] wbits;

  // Phase and address decoding
  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready_q;
  assign wr_done     = access_done & pwrite;
  assign hit_pset    = (paddr == TLIP_ADDR_PEND_SET);
  assign hit_pclr    = (paddr == TLIP_ADDR_PEND_CLR);
  assign hit_active  = (paddr == TLIP_ADDR_ACTIVE);
  assign hit_missed  = (paddr == TLIP_ADDR_MISSED);
  assign hit_status  = (paddr == TLIP_ADDR_IRQ_STATUS);
  assign hit_clear   = (paddr == TLIP_ADDR_IRQ_CLEAR);
  assign hit_enable  = (paddr == TLIP_ADDR_IRQ_ENABLE);
  assign hit_any     = hit_pset | hit_pclr | hit_active | hit_missed
                     | hit_status | hit_clear | hit_enable;

  // Write strobes; only low source bits are kept
  assign wbits     = pwdata[SRC_W-1:0];
  assign wr_pset   = wr_done & hit_pset;
  assign wr_pclr   = wr_done & hit_pclr;
  assign wr_missed = wr_done & hit_missed;
  assign wr_clear  = wr_done & hit_clear;
  assign wr_enable = wr_done & hit_enable;

  // ****************************************************************
  // Source events and core handshake
  // ****************************************************************
  logic [SRC_W-1:0] ack_vec;
  logic [SRC_W-1:0] done_vec;
  logic [SRC_W-1:0] miss_mask;
  logic [SRC_W-1:0] pend_set_vec;
  logic [SRC_W-1:0] pend_clr_vec;
  logic [SRC_W-1:0] miss_set_vec;
  logic [SRC_W-1:0] miss_clr_vec;
  logic [SRC_W-1:0] stat_set_vec;
  logic [SRC_W-1:0] stat_clr_vec;

  // Handshake one-hots
  assign ack_vec  = ack_valid  ? tlip_onehot(ack_index)  : '0;
  assign done_vec = done_valid ? tlip_onehot(done_index) : '0;

  // General timers and debug keep no missed flag
  assign miss_mask = TLIP_MISSED_MASK[SRC_W-1:0]
                   & ~tlip_onehot(TLIP_IDX_W'(general_timer_one_src))
                   & ~tlip_onehot(TLIP_IDX_W'(general_timer_two_src))
                   & ~tlip_onehot(TLIP_IDX_W'(debug_src));

  // Pending: hardware event or software write pends
  assign pend_set_vec = src_event | (wr_pset ? wbits : '0);
  // Pending removed by software clear or by core acceptance
  assign pend_clr_vec = (wr_pclr ? wbits : '0) | ack_vec;

  // Missed: event lands on an already pending source
  assign miss_set_vec = src_event & pending_q & miss_mask;
  assign miss_clr_vec = wr_missed ? (wbits & miss_mask) : '0;

  // Interrupt status: a source newly pended by hardware
  assign stat_set_vec = src_event & ~pending_q;
  assign stat_clr_vec = wr_clear ? wbits : '0;

  // Active set on acceptance, cleared on completion, never by writes
  assign active_d = ack_vec | (active_q & ~done_vec);

  // Enable register write
  assign irq_en_d = wr_enable ? wbits : irq_en_q;

  // ****************************************************************
  // Flag banks
  // ****************************************************************
  tlip_flag_bank #(.W(SRC_W)) u_pending (
    .pclk    (pclk),
    .presetn (presetn),
    .set_vec (pend_set_vec),
    .clr_vec (pend_clr_vec),
    .flag_q  (pending_q)
  );

  tlip_flag_bank #(.W(SRC_W)) u_missed (
    .pclk    (pclk),
    .presetn (presetn),
    .set_vec (miss_set_vec),
    .clr_vec (miss_clr_vec),
    .flag_q  (missed_q)
  );

  tlip_flag_bank #(.W(SRC_W)) u_status (
    .pclk    (pclk),
    .presetn (presetn),
    .set_vec (stat_set_vec),
    .clr_vec (stat_clr_vec),
    .flag_q  (status_q)
  );

  // ****************************************************************
  // Read path
  // ****************************************************************

  // Read mux; pending registers both show pending state
  assign prdata_d = (hit_pset | hit_pclr) ? tlip_widen(pending_q)
                  : hit_active            ? tlip_widen(active_q)
                  : hit_missed            ? tlip_widen(missed_q & miss_mask)
                  : hit_status            ? tlip_widen(status_q)
                  : hit_enable            ? tlip_widen(irq_en_q)
                  : TLIP_RST_ZERO;
  assign pslverr_d = ~hit_any;

  // ****************************************************************
  // Registers
  // ****************************************************************

  // Active and enable storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= TLIP_RST_ZERO[SRC_W-1:0];
      irq_en_q <= TLIP_RST_ZERO[SRC_W-1:0];
    end else begin
      active_q <= active_d;
      irq_en_q <= irq_en_d;
    end
  end

  // APB answer: ready in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= TLIP_RST_ZERO;
    end else begin
      pready_q  <= setup_phase;
      pslverr_q <= setup_phase & pslverr_d;
      prdata_q  <= (setup_phase & ~pwrite) ? prdata_d : TLIP_RST_ZERO;
    end
  end

  // Registered side outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q       <= 1'b0;
      pending_o_q <= TLIP_RST_ZERO[SRC_W-1:0];
      active_o_q  <= TLIP_RST_ZERO[SRC_W-1:0];
    end else begin
      irq_q       <= |(status_q & irq_en_q);
      pending_o_q <= pending_q;
      active_o_q  <= active_q;
    end
  end

  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign irq         = irq_q;
  assign pending_out = pending_o_q;
  assign active_out  = active_o_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // Read of the active register: setup then access
  sequence s_rd_active_setup;
    psel && !penable && !pwrite && hit_active;
  endsequence

  sequence s_access_after;
    psel && penable && pready;
  endsequence

  // Every written one pends its source on the next cycle
  AST_SET_PENDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_pset |=> ((pending_q & $past(wbits)) == $past(wbits)))
    else $error("pending-set write did not pend a source");

  // Zeros in a set write leave pending sources alone
  AST_SET_KEEPS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_pset && !ack_valid) |=> ((pending_q & $past(pending_q)) == $past(pending_q)))
    else $error("pending-set write dropped a pending source");

  // A clear write removes pending unless an event arrived with it
  AST_CLR_UNPENDS: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_pclr |=> ((pending_q & $past(wbits & ~src_event)) == '0))
    else $error("pending-clear write left a source pending");

  // Zeros in a clear write leave pending sources alone
  AST_CLR_KEEPS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_pclr && !ack_valid) |=>
      ((pending_q & $past(pending_q & ~wbits)) == $past(pending_q & ~wbits)))
    else $error("pending-clear write dropped an unselected source");

  // Writes to the active register change nothing
  AST_ACTIVE_RO: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_done && hit_active && !ack_valid && !done_valid) |=> $stable(active_q))
    else $error("write altered the active register");

  // Missed flag set when an event hits a pending masked source
  AST_MISS_SETS: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|(src_event & pending_q & miss_mask)) |=>
      ((missed_q & $past(src_event & pending_q & miss_mask))
       == $past(src_event & pending_q & miss_mask)))
    else $error("missed event not flagged");

  // General timer, debug and upper missed bits never set
  AST_MISS_LOW: assert property (
    @(posedge pclk) disable iff (!presetn)
    (missed_q & ~miss_mask) == '0)
    else $error("missed flag outside bits 15..2");

  // Active read returns active state at the same bit positions
  AST_ACTIVE_MAP: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_rd_active_setup ##1 s_access_after |->
      (prdata[SRC_W-1:0] == $past(active_q, 1)))
    else $error("active read data mismatch");

  // Upper bits of read data are zero
  AST_HIGH_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |-> (prdata[31:SRC_W] == '0))
    else $error("read data upper bits not zero");

endmodule : tlip_top

// *** shared/tlip_pkg.sv ***
package tlip_pkg;

  // ****************************************************************
  // Register byte addresses
  // ****************************************************************
  localparam logic [31:0] TLIP_ADDR_PEND_SET   = 32'hE000_E200;
  localparam logic [31:0] TLIP_ADDR_PEND_CLR   = 32'hE000_E280;
  localparam logic [31:0] TLIP_ADDR_ACTIVE     = 32'hE000_E300;
  localparam logic [31:0] TLIP_ADDR_MISSED     = 32'h4000_A820;
  localparam logic [31:0] TLIP_ADDR_IRQ_STATUS = 32'hE000_E380;
  localparam logic [31:0] TLIP_ADDR_IRQ_CLEAR  = 32'hE000_E384;
  localparam logic [31:0] TLIP_ADDR_IRQ_ENABLE = 32'hE000_E388;

  // ****************************************************************
  // Reset values and widths
  // ****************************************************************
  localparam logic [31:0] TLIP_RST_ZERO = 32'h0000_0000;
  localparam int          TLIP_NUM_SRC  = 17;
  localparam int          TLIP_IDX_W    = 5;
  localparam int          TLIP_DATA_W   = 32;

  // ****************************************************************
  // Source bit positions, shared by every per-source register
  // ****************************************************************
  localparam int general_timer_one_src = 0;
  localparam int general_timer_two_src = 1;
  localparam int management_src        = 2;
  localparam int baseband_src          = 3;
  localparam int sleep_timer_src       = 4;
  localparam int serial_ctrl_one_src   = 5;
  localparam int serial_ctrl_two_src   = 6;
  localparam int security_src          = 7;
  localparam int mac_timer_src         = 8;
  localparam int mac_transmit_src      = 9;
  localparam int mac_receive_src       = 10;
  localparam int converter_src         = 11;
  localparam int ext_line_a_src        = 12;
  localparam int ext_line_b_src        = 13;
  localparam int ext_line_c_src        = 14;
  localparam int ext_line_d_src        = 15;
  localparam int debug_src             = 16;

  // Missed-flag field spans bits 15 down to 2
  localparam logic [31:0] TLIP_MISSED_MASK = 32'h0000_FFFC;

endpackage : tlip_pkg

// *** hw/tlip_flag_bank.sv ***
`timescale 1ns/10ps

// ****************************************************************
// Bank of sticky flags; a set in the same cycle as a clear wins
// ****************************************************************
module tlip_flag_bank
  import tlip_pkg::*;
#(
  parameter int W = TLIP_NUM_SRC
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] set_vec,
  input  wire logic [W-1:0] clr_vec,
  output logic      [W-1:0] flag_q
);

  logic [W-1:0] flag_d;

  // Set has priority over clear
  assign flag_d = set_vec | (flag_q & ~clr_vec);

  // Flag storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= TLIP_RST_ZERO[W-1:0];
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : tlip_flag_bank

// *** testbench/tlip_src_model.sv ***
`timescale 1ns/10ps

// ****************************************************************
// Peripheral event sources and the core's accept/finish strobes
// ****************************************************************
module tlip_src_model
  import tlip_pkg::*;
(
  input  wire logic                    pclk,
  output logic      [TLIP_NUM_SRC-1:0] src_event,
  output logic                         ack_valid,
  output logic      [TLIP_IDX_W-1:0]   ack_index,
  output logic                         done_valid,
  output logic      [TLIP_IDX_W-1:0]   done_index
);
  // Idle at time zero
  initial begin
    src_event  = '0;
    ack_valid  = 1'b0;
    ack_index  = '0;
    done_valid = 1'b0;
    done_index = '0;
  end

  // One-cycle event pulse on the given sources
  task automatic fire(input logic [TLIP_NUM_SRC-1:0] v);
    @(posedge pclk);
    src_event <= v;
    @(posedge pclk);
    src_event <= '0;
  endtask : fire

  // Core accepts a source; index scrambled once the strobe drops
  task automatic ack(input logic [TLIP_IDX_W-1:0] i);
    @(posedge pclk);
    ack_valid <= 1'b1;
    ack_index <= i;
    @(posedge pclk);
    ack_valid <= 1'b0;
    ack_index <= ~i;
  endtask : ack

  // Core finishes a source; index scrambled once the strobe drops
  task automatic done(input logic [TLIP_IDX_W-1:0] i);
    @(posedge pclk);
    done_valid <= 1'b1;
    done_index <= i;
    @(posedge pclk);
    done_valid <= 1'b0;
    done_index <= ~i;
  endtask : done
endmodule : tlip_src_model

// *** testbench/tlip_top_tb.sv ***
`timescale 1ns/10ps

module tlip_top_tb;
  import tlip_pkg::*;
  logic                    pclk;
  logic                    presetn;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic                    pready;
  logic                    pslverr;
  logic                    irq;
  logic                    er;
  logic                    ack_valid;
  logic                    done_valid;
  logic [31:0]             paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic [31:0]             rd;
  logic [TLIP_IDX_W-1:0]   ack_index;
  logic [TLIP_IDX_W-1:0]   done_index;
  logic [TLIP_NUM_SRC-1:0] src_event;
  logic [TLIP_NUM_SRC-1:0] pending_out;
  logic [TLIP_NUM_SRC-1:0] active_out;
  logic [TLIP_NUM_SRC-1:0] b;
  int                      fail_count = 0;
  int                      checks = 0;
  int                      cycles = 0;

  // ****************************************************************
  // Clock, instances, hang guard
  // ****************************************************************
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  tlip_top dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_event(src_event), .ack_valid(ack_valid),
    .ack_index(ack_index), .done_valid(done_valid), .done_index(done_index),
    .pending_out(pending_out), .active_out(active_out), .irq(irq));

  tlip_src_model u_src (.pclk(pclk), .src_event(src_event), .ack_valid(ack_valid),
    .ack_index(ack_index), .done_valid(done_valid), .done_index(done_index));

  // Cut a hung run short
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high, only the hang guard ends a wait
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : wr

  task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(what, exp, rd);
    chk({what, "_err"}, 32'h0000_0000, 32'(er));
  endtask : rdchk

  task automatic wait_cy(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : wait_cy

  task automatic wrap_up();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 32'h0000_0000;
    pwdata  = 32'h0000_0000;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values
    rdchk("pend_rst", TLIP_ADDR_PEND_SET, TLIP_RST_ZERO);
    rdchk("act_rst", TLIP_ADDR_ACTIVE, TLIP_RST_ZERO);
    rdchk("miss_rst", TLIP_ADDR_MISSED, TLIP_RST_ZERO);
    // Set and clear pending by software, upper bits dropped
    wr(TLIP_ADDR_PEND_SET, 32'hFFFF_FFFF);
    rdchk("pend_all", TLIP_ADDR_PEND_SET, 32'h0001_FFFF);
    chk("pending_out", 32'h0001_FFFF, 32'(pending_out));
    wr(TLIP_ADDR_PEND_SET, 32'h0000_0000);
    rdchk("pend_zero_set", TLIP_ADDR_PEND_SET, 32'h0001_FFFF);
    wr(TLIP_ADDR_PEND_CLR, 32'h0000_0005);
    rdchk("pend_clr5", TLIP_ADDR_PEND_CLR, 32'h0001_FFFA);
    wr(TLIP_ADDR_PEND_CLR, 32'h0000_0000);
    rdchk("pend_zero_clr", TLIP_ADDR_PEND_CLR, 32'h0001_FFFA);
    wr(TLIP_ADDR_PEND_CLR, 32'hFFFF_FFFF);
    rdchk("pend_clr_all", TLIP_ADDR_PEND_SET, 32'h0000_0000);
    // Each source lands on its own bit in pending and active
    for (int i = 0; i < TLIP_NUM_SRC; i++) begin
      b = '0;
      b[i] = 1'b1;
      u_src.fire(b);
      wait_cy(2);
      chk("pending_out_src", 32'(b), 32'(pending_out));
      rdchk("pend_src", TLIP_ADDR_PEND_SET, 32'(b));
      u_src.ack(5'(i));
      wait_cy(2);
      chk("active_out_src", 32'(b), 32'(active_out));
      rdchk("active_src", TLIP_ADDR_ACTIVE, 32'(b));
      wr(TLIP_ADDR_ACTIVE, 32'h0000_0000);
      rdchk("active_ro", TLIP_ADDR_ACTIVE, 32'(b));
      u_src.done(5'(i));
      wait_cy(2);
      chk("active_done", 32'h0000_0000, 32'(active_out));
    end
    wr(TLIP_ADDR_IRQ_CLEAR, 32'hFFFF_FFFF);
    // Missed flags only for an event while already pending
    u_src.fire('1);
    wait_cy(2);
    rdchk("miss_first", TLIP_ADDR_MISSED, 32'h0000_0000);
    u_src.fire('1);
    wait_cy(2);
    rdchk("miss_second", TLIP_ADDR_MISSED, 32'h0000_FFFC);
    wr(TLIP_ADDR_MISSED, 32'hFFFF_FFFF);
    rdchk("miss_clear", TLIP_ADDR_MISSED, 32'h0000_0000);
    wr(TLIP_ADDR_PEND_CLR, 32'hFFFF_FFFF);
    wr(TLIP_ADDR_IRQ_CLEAR, 32'hFFFF_FFFF);
    // Interrupt raised, masked, unmasked and cleared
    wr(TLIP_ADDR_IRQ_ENABLE, 32'h0000_0008);
    u_src.fire(17'h0_0008);
    wait_cy(3);
    chk("irq_raise", 32'h1, 32'(irq));
    wr(TLIP_ADDR_IRQ_ENABLE, 32'h0000_0000);
    wait_cy(2);
    chk("irq_mask", 32'h0, 32'(irq));
    wr(TLIP_ADDR_IRQ_ENABLE, 32'h0000_0008);
    wait_cy(2);
    chk("irq_unmask", 32'h1, 32'(irq));
    wr(TLIP_ADDR_IRQ_CLEAR, 32'h0000_0008);
    wait_cy(2);
    chk("irq_clear", 32'h0, 32'(irq));
    rdchk("irq_status", TLIP_ADDR_IRQ_STATUS, 32'h0000_0000);
    // Unmapped address answers with an error and zero data
    xfer(32'h0000_1000, 1'b0, 32'h0000_0000);
    chk("unmapped_err", 32'h1, 32'(er));
    chk("unmapped_data", 32'h0, rd);
    wrap_up();
  end
endmodule : tlip_top_tb
